// [hdl/hub_override_pkg.sv]
// package: register map, field layout and bus constants of the hub override bank
package hub_override_pkg;
  localparam logic [11:0] HUB_CONFIG_OVERRIDE_ADDR  = 12'h014;
  localparam logic [11:0] PORT_ENABLE_OVERRIDE_ADDR = 12'h018;
  localparam logic [11:0] OVERRIDE_STATUS_ADDR      = 12'h01C;
  localparam int          FORCE_HUB_CONFIGURED_BIT            = 0;
  localparam int          PORT_FIELD_W              = 6;
  localparam logic [5:0]  PORT_FIELD_RESET          = 6'h00;
  localparam logic [1:0]  RESP_OKAY                 = 2'b00;
  localparam logic [1:0]  RESP_SLVERR               = 2'b10;
  localparam logic [31:0] DATA_ZERO                 = 32'h0000_0000;

  typedef struct packed {
    logic        hub_configured;
    logic        port_enabled;
    logic [5:0]  port_speed;
  } hub_state_s;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_e;
endpackage

// [hdl/strobe_merge.sv]
// module: applies AXI4-Lite byte strobes to a stored word
`timescale 1ns/1ps
module strobe_merge (
  // data
  input  wire logic [31:0] old_word,
  input  wire logic [31:0] new_word,
  input  wire logic [3:0]  strb,
  // result
  output logic      [31:0] merged
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign merged[g*8 +: 8] = strb[g] ? new_word[g*8 +: 8] : old_word[g*8 +: 8];
    end
  endgenerate
endmodule

// [hdl/hub_force_config_override.sv]
// module: root hub force-configure and port-enable override registers, AXI4-Lite slave
`timescale 1ns/1ps
module hub_force_config_override
  import hub_override_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // hub state toward the root hub logic
  output logic             hub_configured,
  output logic             port_enabled,
  output logic [5:0]       port_speed
);

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == HUB_CONFIG_OVERRIDE_ADDR) || (a == PORT_ENABLE_OVERRIDE_ADDR) ||
           (a == OVERRIDE_STATUS_ADDR);
  endfunction

  logic [11:0] awaddr_ff;
  logic        aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        w_held_ff;
  wr_state_e   wr_state_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  hub_state_s  state_ff;
  logic        force_flag_ff;
  logic [31:0] merged;
  logic        do_write;
  logic [31:0] nxt_rdata;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic        arready_ff;

  // handshake outputs are flip-flops so no bus output is a decode of state
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign hub_configured = state_ff.hub_configured;
  assign port_enabled   = state_ff.port_enabled;
  assign port_speed     = state_ff.port_speed;

  // address and data are each taken once, in either order, while no response is pending;
  // each half closes on its own handshake and reopens only when the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b1;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
    end else if (bvalid_ff && s_axi_bready) begin
      wready_ff <= 1'b1;
    end
  end

  // response stands from the commit edge until bready is seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // one read in flight: the address channel stays shut while read data stands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 12'h000;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= DATA_ZERO;
      wstrb_ff  <= 4'h0;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end
  end

  // the write commits one cycle after both halves are held
  assign do_write = aw_held_ff & w_held_ff & (wr_state_ff == WR_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= WR_IDLE;
      bresp_ff    <= RESP_OKAY;
    end else begin
      case (wr_state_ff)
        WR_IDLE: begin
          if (do_write) begin
            wr_state_ff <= WR_RESP;
            bresp_ff    <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_ff <= WR_IDLE;
          end
        end
        default: begin
          wr_state_ff <= WR_IDLE;
        end
      endcase
    end
  end

  strobe_merge u_merge (
    .old_word (DATA_ZERO),
    .new_word (wdata_ff),
    .strb     (wstrb_ff),
    .merged   (merged)
  );

  // reserved bits are ignored on write; software is expected to keep them zero
  // reserved bits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_flag_ff <= 1'b0;
    end else if (do_write && awaddr_ff == HUB_CONFIG_OVERRIDE_ADDR &&
                 merged[FORCE_HUB_CONFIGURED_BIT]) begin
      force_flag_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '{hub_configured: 1'b0, port_enabled: 1'b0, port_speed: PORT_FIELD_RESET};
    end else if (do_write) begin
      if (awaddr_ff == HUB_CONFIG_OVERRIDE_ADDR && merged[FORCE_HUB_CONFIGURED_BIT]) begin
        state_ff.hub_configured <= 1'b1;
      end
      // zero write has no effect: no branch clears hub_configured
      if (awaddr_ff == PORT_ENABLE_OVERRIDE_ADDR && force_flag_ff && wstrb_ff[0]) begin
        state_ff.port_speed   <= wdata_ff[PORT_FIELD_W-1:0];
        state_ff.port_enabled <= (wdata_ff[PORT_FIELD_W-1:0] != PORT_FIELD_RESET);
      end
    end
  end

  always_comb begin
    nxt_rdata = DATA_ZERO;
    case (s_axi_araddr)
      HUB_CONFIG_OVERRIDE_ADDR:  nxt_rdata = DATA_ZERO;
      PORT_ENABLE_OVERRIDE_ADDR: nxt_rdata = {26'h000_0000, state_ff.port_speed};
      OVERRIDE_STATUS_ADDR:      nxt_rdata = {29'h0000_0000, force_flag_ff,
                                              state_ff.port_enabled,
                                              state_ff.hub_configured};
      default:                   nxt_rdata = DATA_ZERO;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= DATA_ZERO;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

// [dv/hub_override_checker.sv]
// checker: handshake and hub state properties of the override bank
`timescale 1ns/1ps
module hub_override_checker
  import hub_override_pkg::*;
(
  // watched ports
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, hub_configured, port_enabled,
  input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic [5:0]  port_speed
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic rd   = s_axi_arvalid && s_axi_arready;
  property p_wl; both |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid; endproperty
  a_wl: assert property (p_wl) else $error("late write answer");
  property p_rl; rd |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rl: assert property (p_rl) else $error("late read answer");
  property p_rz; rd && s_axi_araddr == HUB_CONFIG_OVERRIDE_ADDR |=> s_axi_rdata == DATA_ZERO;
  endproperty
  a_rz: assert property (p_rz) else $error("trigger bit read nonzero");
  property p_set; both && s_axi_awaddr == HUB_CONFIG_OVERRIDE_ADDR && s_axi_wdata[0]
    && s_axi_wstrb[0] |-> ##2 hub_configured; endproperty
  a_set: assert property (p_set) else $error("hub not configured");
  property p_keep; hub_configured |=> hub_configured; endproperty
  a_keep: assert property (p_keep) else $error("hub state lost");
  property p_en; port_enabled == (port_speed != PORT_FIELD_RESET); endproperty
  a_en: assert property (p_en) else $error("port enable wrong");
  property p_gate; !hub_configured |-> port_speed == PORT_FIELD_RESET; endproperty
  a_gate: assert property (p_gate) else $error("ungated port write");
  property p_spd; !$stable(port_speed) |-> $rose(s_axi_bvalid); endproperty
  a_spd: assert property (p_spd) else $error("speed moved alone");
  c_hub: cover property ($rose(hub_configured));
  c_port: cover property ($rose(port_enabled));
  c_rd: cover property (rd);
endmodule
bind hub_force_config_override hub_override_checker u_hub_override_checker (.*);

// [dv/testbench.sv]
// testbench: drives the override bank over its register bus and checks the hub outputs
`timescale 1ns/1ps
module testbench;
  import hub_override_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        hub_configured, port_enabled;
  logic [5:0]  port_speed, spd;
  logic [33:0] exp_q[$];
  int          mismatches = 0, total_checks = 0;
  always #2 aclk = ~aclk;
  hub_force_config_override u_hub_force_config_override (.*);
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one write (w high) or read; expected answer queued for the monitor
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back({r, w ? DATA_ZERO : d});
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_bvalid || s_axi_rvalid) && n < 64);
    if (!(s_axi_bvalid || s_axi_rvalid)) begin
      mismatches++;
      conclude();
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, DATA_ZERO}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end
  initial begin
    void'($urandom(7));
    spd = 6'($urandom_range(63, 1));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(0, OVERRIDE_STATUS_ADDR, DATA_ZERO, RESP_OKAY);
    xfer(1, PORT_ENABLE_OVERRIDE_ADDR, {26'h0, spd}, RESP_OKAY);
    xfer(0, PORT_ENABLE_OVERRIDE_ADDR, DATA_ZERO, RESP_OKAY);
    xfer(1, HUB_CONFIG_OVERRIDE_ADDR, DATA_ZERO, RESP_OKAY);
    check({33'h0, hub_configured}, 34'h0);
    xfer(1, HUB_CONFIG_OVERRIDE_ADDR, 32'h0000_0001, RESP_OKAY);
    check({33'h0, hub_configured}, 34'h1);
    xfer(0, HUB_CONFIG_OVERRIDE_ADDR, DATA_ZERO, RESP_OKAY);
    xfer(1, HUB_CONFIG_OVERRIDE_ADDR, DATA_ZERO, RESP_OKAY);
    check({33'h0, hub_configured}, 34'h1);
    xfer(1, PORT_ENABLE_OVERRIDE_ADDR, {26'h0, spd}, RESP_OKAY);
    check({27'h0, port_enabled, port_speed}, {27'h0, 1'b1, spd});
    xfer(0, PORT_ENABLE_OVERRIDE_ADDR, {26'h0, spd}, RESP_OKAY);
    xfer(0, OVERRIDE_STATUS_ADDR, 32'h0000_0007, RESP_OKAY);
    xfer(1, PORT_ENABLE_OVERRIDE_ADDR, DATA_ZERO, RESP_OKAY);
    check({27'h0, port_enabled, port_speed}, 34'h0);
    // unmapped write must change nothing
    xfer(1, 12'h020, 32'hffff_ffff, RESP_SLVERR);
    xfer(0, OVERRIDE_STATUS_ADDR, 32'h0000_0005, RESP_OKAY);
    // second reset mid-run must drop the force flag and the hub state
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // without byte lane 0 the trigger bit is not written
    s_axi_wstrb <= 4'he;
    xfer(1, HUB_CONFIG_OVERRIDE_ADDR, 32'h0000_0001, RESP_OKAY);
    check({33'h0, hub_configured}, 34'h0);
    s_axi_wstrb <= 4'hf;
    xfer(1, PORT_ENABLE_OVERRIDE_ADDR, {26'h0, spd}, RESP_OKAY);
    check({27'h0, port_enabled, port_speed}, 34'h0);
    xfer(0, OVERRIDE_STATUS_ADDR, DATA_ZERO, RESP_OKAY);
    conclude();
  end
endmodule
